// ==== design/qorb_pkg.sv ====
// Constants and carrier types for the four-register output bank.
// Assumes one system clock and an active-low asynchronous reset.
package qorb_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_REGS = 4;
  localparam int unsigned ADDR_W = 2;
  // Word offsets of the four registers
  localparam logic [1:0] OFF_REG0 = 2'h0;
  localparam logic [1:0] OFF_REG1 = 2'h1;
  localparam logic [1:0] OFF_REG2 = 2'h2;
  localparam logic [1:0] OFF_REG3 = 2'h3;
  // Reset values
  localparam logic [31:0] RST_OUT = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  // Timing in cycles
  localparam int unsigned WRITE_WAIT = 0;
  localparam int unsigned READ_WAIT = 1;
  localparam int unsigned READ_LATENCY = 1;

  // Slave request from the master
  typedef struct packed {
    logic [1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } qorb_req_t;

  // Slave answer to the master
  typedef struct packed {
    logic waitrequest;
    logic readdatavalid;
    logic [31:0] readdata;
  } qorb_rsp_t;
endpackage : qorb_pkg

// ==== design/qorb_word_reg.sv ====
// One 32-bit output register with a load enable.
// Assumes clk_sys and reset_n shared with the bank.
module qorb_word_reg (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Load
  input wire logic load,
  input wire logic [31:0] din,
  // Contents
  output logic [31:0] dout
);
  typedef struct packed {
    logic [31:0] word;
  } qorb_word_state_t;

  qorb_word_state_t st_q;
  qorb_word_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (load) begin
      st_d.word = din;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q.word <= qorb_pkg::RST_OUT;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.word;
endmodule : qorb_word_reg

// ==== design/qorb_bank.sv ====
// Four 32-bit output registers behind one memory-mapped slave port.
// Assumes a single master, synchronous inputs and one 50 MHz clock.
// Functional notes
// R01: Four separate output registers, each at its own word address, readable and writable.
// R02: A write loads only the one addressed register; others keep their value.
// R03: Read address bits drive the read multiplexer select directly.
// R04: Read data is an exact copy of the addressed register.
// R05: Mux output is captured into a read data register when read is asserted.
// R06: Writes take no wait state; reads take one wait state.
// R07: Pipelined mode: no wait states, read latency one, one read per cycle.
// R08: Reset clears all registers and read data; registers drive output lines.
module qorb_bank #(
  parameter bit PIPELINED = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Slave port
  input wire qorb_pkg::qorb_req_t req,
  output qorb_pkg::qorb_rsp_t rsp,
  // Output lines
  output logic [31:0] out0,
  output logic [31:0] out1,
  output logic [31:0] out2,
  output logic [31:0] out3
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] rdata;
    logic rd_pend;
    logic rvalid;
  } qorb_bank_state_t;

  qorb_bank_state_t st_q;
  qorb_bank_state_t st_d;
  logic [3:0] load;
  logic [31:0] regs [4];
  logic [31:0] mux_out;
  logic rd_take;

  // ****************************************
  // Decoder and register file
  // ****************************************
  always_comb begin
    load = 4'h0;
    if (req.write) begin
      load[req.address] = 1'b1; // R02
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_reg
    qorb_word_reg u_reg ( // R01
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(load[i]),
      .din(req.writedata),
      .dout(regs[i])
    );
  end

  assign out0 = regs[0]; // R08
  assign out1 = regs[1];
  assign out2 = regs[2];
  assign out3 = regs[3];

  // ****************************************
  // Read path
  // ****************************************
  assign mux_out = regs[req.address]; // R03 R04
  // Fixed-wait mode takes a read on its second cycle; pipelined takes it at once
  assign rd_take = req.read && (PIPELINED || st_q.rd_pend);

  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    if (PIPELINED) begin
      st_d.rd_pend = 1'b0;
    end else begin
      st_d.rd_pend = req.read && !st_q.rd_pend; // R06
    end
    if (req.read) begin
      st_d.rdata = mux_out; // R05
    end
    if (rd_take) begin
      st_d.rvalid = 1'b1; // R07
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q.rdata <= qorb_pkg::RST_RDATA; // R08
      st_q.rd_pend <= 1'b0;
      st_q.rvalid <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Wait asserted only in the first cycle of a fixed-wait read
  assign rsp.waitrequest = !PIPELINED && req.read && !st_q.rd_pend; // R06
  assign rsp.readdatavalid = st_q.rvalid;
  assign rsp.readdata = st_q.rdata;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_write(logic [1:0] a);
    req.write && !req.read && req.address == a;
  endsequence

  a_write_loads: assert property (@(posedge clk_sys) disable iff (!reset_n) // R02
    req.write |=> regs[$past(req.address)] == $past(req.writedata))
    else $error("Written register did not take the data");
  a_other_kept: assert property (@(posedge clk_sys) disable iff (!reset_n) // R02
    s_write(2'h0) |=> regs[1] == $past(regs[1]) && regs[3] == $past(regs[3]))
    else $error("Unaddressed register changed");
  a_regs_sep: assert property (@(posedge clk_sys) disable iff (!reset_n) // R01
    s_write(2'h3) |=> regs[2] == $past(regs[2]))
    else $error("Register three write touched register two");
  a_read_copy: assert property (@(posedge clk_sys) disable iff (!reset_n) // R04
    (req.read && !req.write) |=> rsp.readdata == $past(mux_out))
    else $error("Read data is not the addressed register");
  a_mux_sel: assert property (@(posedge clk_sys) disable iff (!reset_n) // R03
    req.address == 2'h2 |-> mux_out == regs[2])
    else $error("Mux select does not follow address");
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // R05
    !req.read |=> $stable(rsp.readdata))
    else $error("Read data changed without a read");
  a_write_nowait: assert property (@(posedge clk_sys) disable iff (!reset_n) // R06
    (req.write && !req.read) |-> !rsp.waitrequest)
    else $error("Write stalled");
  a_read_onewait: assert property (@(posedge clk_sys) disable iff (!reset_n) // R06
    (!PIPELINED && req.read && !st_q.rd_pend) |-> rsp.waitrequest ##1
      (!req.read || !rsp.waitrequest))
    else $error("Read wait state not exactly one");
  a_pipe_valid: assert property (@(posedge clk_sys) disable iff (!reset_n) // R07
    (PIPELINED && req.read) |=> rsp.readdatavalid)
    else $error("Pipelined read valid not one cycle later");
  a_out_drive: assert property (@(posedge clk_sys) disable iff (!reset_n) // R08
    out0 == regs[0] && out3 == regs[3])
    else $error("Output lines differ from registers");

  // ****************************************
  // Checks: write path
  // ****************************************
  a_keep_w1: assert property (@(posedge clk_sys) disable iff (!reset_n) // R02
    s_write(2'h1) |=> regs[0] == $past(regs[0]) && regs[2] == $past(regs[2]))
    else $error("Register one write touched another register");
  a_keep_w2: assert property (@(posedge clk_sys) disable iff (!reset_n) // R02
    s_write(2'h2) |=> regs[1] == $past(regs[1]) && regs[3] == $past(regs[3]))
    else $error("Register two write touched another register");
  a_keep_w3: assert property (@(posedge clk_sys) disable iff (!reset_n) // R02
    s_write(2'h3) |=> regs[0] == $past(regs[0]) && regs[1] == $past(regs[1]))
    else $error("Register three write touched another register");
  a_keep_w0: assert property (@(posedge clk_sys) disable iff (!reset_n) // R02
    s_write(2'h0) |=> regs[2] == $past(regs[2]))
    else $error("Register zero write touched register two");
  a_idle_keep: assert property (@(posedge clk_sys) disable iff (!reset_n) // R02
    !req.write |=> $stable(regs[0]) && $stable(regs[1]))
    else $error("Register changed without a write");
  a_idle_keep_hi: assert property (@(posedge clk_sys) disable iff (!reset_n) // R02
    !req.write |=> $stable(regs[2]) && $stable(regs[3]))
    else $error("Upper register changed without a write");
  a_out_drive_mid: assert property (@(posedge clk_sys) disable iff (!reset_n) // R08
    out1 == regs[1] && out2 == regs[2])
    else $error("Middle output lines differ from registers");

  // ****************************************
  // Checks: read path
  // ****************************************
  sequence s_rd_first;
    !PIPELINED && req.read && !$past(req.read);
  endsequence

  sequence s_rd_taken;
    req.read && !rsp.waitrequest;
  endsequence

  a_wait_first: assert property (@(posedge clk_sys) disable iff (!reset_n) // R06
    s_rd_first |-> rsp.waitrequest)
    else $error("First read cycle not stalled");
  a_wait_second: assert property (@(posedge clk_sys) disable iff (!reset_n) // R06
    s_rd_first ##1 req.read |-> !rsp.waitrequest)
    else $error("Read stalled more than one cycle");
  a_rd_answer: assert property (@(posedge clk_sys) disable iff (!reset_n) // R06
    s_rd_first ##1 s_rd_taken |=> rsp.readdatavalid)
    else $error("Taken read gave no valid pulse");
  a_rd_data: assert property (@(posedge clk_sys) disable iff (!reset_n) // R04
    s_rd_taken |=> rsp.readdata == $past(mux_out))
    else $error("Taken read returned wrong data");
  a_valid_cause: assert property (@(posedge clk_sys) disable iff (!reset_n) // R06
    rsp.readdatavalid |-> $past(req.read))
    else $error("Valid pulse without a read");
  a_valid_once: assert property (@(posedge clk_sys) disable iff (!reset_n) // R06
    (!PIPELINED && rsp.readdatavalid) |-> !$past(rsp.waitrequest))
    else $error("Valid pulse after a stalled cycle");
  a_no_wait_idle: assert property (@(posedge clk_sys) disable iff (!reset_n) // R06
    !req.read |-> !rsp.waitrequest)
    else $error("Stall raised without a read");
  a_mux_sel0: assert property (@(posedge clk_sys) disable iff (!reset_n) // R03
    req.address == 2'h0 |-> mux_out == regs[0])
    else $error("Mux select zero does not follow address");
  a_mux_sel1: assert property (@(posedge clk_sys) disable iff (!reset_n) // R03
    req.address == 2'h1 |-> mux_out == regs[1])
    else $error("Mux select one does not follow address");
  a_mux_sel3: assert property (@(posedge clk_sys) disable iff (!reset_n) // R03
    req.address == 2'h3 |-> mux_out == regs[3])
    else $error("Mux select three does not follow address");
  a_rdata_cap: assert property (@(posedge clk_sys) disable iff (!reset_n) // R05
    req.read |=> rsp.readdata == $past(mux_out))
    else $error("Read data register missed the mux output");

  // ****************************************
  // Checks: pipelined mode
  // ****************************************
  a_pipe_nowait: assert property (@(posedge clk_sys) disable iff (!reset_n) // R07
    PIPELINED |-> !rsp.waitrequest)
    else $error("Pipelined slave stalled");
  a_pipe_data: assert property (@(posedge clk_sys) disable iff (!reset_n) // R07
    (PIPELINED && req.read) |=> rsp.readdata == $past(mux_out))
    else $error("Pipelined read data wrong");
  a_pipe_idle: assert property (@(posedge clk_sys) disable iff (!reset_n) // R07
    (PIPELINED && !req.read) |=> !rsp.readdatavalid)
    else $error("Pipelined valid without a read");
  a_pipe_pend: assert property (@(posedge clk_sys) disable iff (!reset_n) // R07
    PIPELINED |-> !st_q.rd_pend)
    else $error("Pipelined slave holds a pending read");
endmodule : qorb_bank

// ==== sim/qorb_host.sv ====
// Bus master model facing the output bank slave port.
// Assumes tasks are called just after a rising edge of clk_sys.
module qorb_host (
  // Clock
  input wire logic clk_sys,
  // Slave port
  output qorb_pkg::qorb_req_t req,
  input wire qorb_pkg::qorb_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // Write, taken at the next edge with no wait
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    req <= '{address: a, read: 1'b0, write: 1'b1, writedata: d};
    @(posedge clk_sys);
  endtask : wr
  // Read held until the edge that sees waitrequest low
  task automatic rd(input logic [1:0] a, output logic [31:0] d, output int nw);
    logic w;
    nw = 0;
    req <= '{address: a, read: 1'b1, write: 1'b0, writedata: 32'h5A5A_5A5A};
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      w = rsp.waitrequest;
      d = rsp.readdata;
      @(posedge clk_sys);
      if (w === 1'b0) break;
      nw++;
    end
  endtask : rd
  // Back-to-back reads, one address per edge, for the zero-wait slave
  task automatic rd_pipe(input logic [3:0][1:0] a);
    for (int i = 0; i < 4; i++) begin
      req <= '{address: a[i], read: 1'b1, write: 1'b0, writedata: 32'h5A5A_5A5A};
      @(posedge clk_sys);
    end
    idle();
  endtask : rd_pipe
  // Released address and data lines show the inverse of their last value; read and write go low
  task automatic idle();
    req <= '{address: ~req.address, read: 1'b0, write: 1'b0, writedata: ~req.writedata};
  endtask : idle
endmodule : qorb_host

// ==== sim/tb.sv ====
// Self-checking bench for the four-register output bank.
// Checks u_dut in the default one-wait-state read configuration and u_dut_pipe in pipelined mode.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  qorb_pkg::qorb_req_t req;
  qorb_pkg::qorb_rsp_t rsp;
  logic [3:0][31:0] outs;
  logic [3:0][31:0] exp_q;
  logic [31:0] d;
  qorb_pkg::qorb_rsp_t rsp_p;
  logic [3:0][31:0] outs_p;
  int nw;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #10 clk_sys = ~clk_sys;
  qorb_bank u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .req(req), .rsp(rsp),
    .out0(outs[0]), .out1(outs[1]), .out2(outs[2]), .out3(outs[3]));
  qorb_host u_host (.clk_sys(clk_sys), .req(req), .rsp(rsp));
  qorb_bank #(.PIPELINED(1'b1)) u_dut_pipe (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
    .rsp(rsp_p), .out0(outs_p[0]), .out1(outs_p[1]), .out2(outs_p[2]), .out3(outs_p[3]));
  // ****************
  // Checks
  // ****************
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic chk_outs();
    for (int i = 0; i < 4; i++) begin
      chk("out", exp_q[i], outs[i]);
      chk("out_pipe", exp_q[i], outs_p[i]);
    end
  endtask : chk_outs
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    exp_q = '0;
    chk_outs();
    chk("rdata", 32'h0000_0000, rsp.readdata);
    chk("rvalid", 32'h0, {31'h0, rsp.readdatavalid});
  endtask : t_reset
  task automatic t_write();
    for (int i = 0; i < 4; i++) begin
      u_host.wr(i[1:0], 32'hC3A5_0F00 + 32'(i));
      u_host.idle();
      exp_q[i] = 32'hC3A5_0F00 + 32'(i);
      @(negedge clk_sys);
      chk_outs();
      @(posedge clk_sys);
    end
    u_host.wr(2'h2, 32'hFFFF_0001);
    u_host.wr(2'h0, 32'h0000_FFFE);
    exp_q[2] = 32'hFFFF_0001;
    exp_q[0] = 32'h0000_FFFE;
    u_host.idle();
    @(negedge clk_sys);
    chk_outs();
  endtask : t_write
  task automatic t_read();
    for (int i = 3; i >= 0; i--) begin
      u_host.rd(i[1:0], d, nw);
      u_host.idle();
      chk("rd", exp_q[i], d);
      chk("wait", 32'h1, 32'(nw));
      @(negedge clk_sys);
      chk("rvalid", 32'h1, {31'h0, rsp.readdatavalid});
      chk("hold", exp_q[i], rsp.readdata);
      @(posedge clk_sys);
    end
  endtask : t_read
  task automatic t_pipe();
    logic [3:0][1:0] seq_a = {2'h1, 2'h3, 2'h0, 2'h2};
    fork
      u_host.rd_pipe(seq_a);
      begin
        @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
          @(negedge clk_sys);
          chk("pipe_rd", exp_q[seq_a[k]], rsp_p.readdata);
          chk("pipe_valid", 32'h1, {31'h0, rsp_p.readdatavalid});
          chk("pipe_wait", 32'h0, {31'h0, rsp_p.waitrequest});
          @(posedge clk_sys);
        end
      end
    join
  endtask : t_pipe
  task automatic t_rst_mid();
    reset_n <= 1'b0;
    @(negedge clk_sys);
    exp_q = '0;
    chk_outs();
    chk("rdata", 32'h0000_0000, rsp.readdata);
    chk("rdata_pipe", 32'h0000_0000, rsp_p.readdata);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
  endtask : t_rst_mid
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    t_reset();
    @(posedge clk_sys);
    t_write();
    @(posedge clk_sys);
    t_read();
    t_pipe();
    t_rst_mid();
    report_and_stop();
  end
endmodule : tb
